// ---- bench/pss_mgmt_model.sv ----
`timescale 1ns/1ps

// Management controller stand-in: turns each request into a one-cycle read strobe.
module pss_mgmt_model (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic go,
  input wire logic [4:0] go_addr,
  output logic rd_strobe,
  output logic [4:0] rd_addr
);
  // The strobe follows a request by one edge; an idle address wanders so it is never trusted.
  always_ff @(posedge ref_clk) begin
    rd_strobe <= go & ~reset;
    rd_addr <= (go | reset) ? go_addr : ~rd_addr;
  end
endmodule // pss_mgmt_model

// ---- bench/test_pss_summary.sv ----
`timescale 1ns/1ps

// Self-checking bench for the upper summary status word.
module test_pss_summary;
  logic ref_clk = 1'h0; // Device clock, 25 ns period.
  logic reset = 1'h1;
  logic go = 1'h0;
  logic [4:0] go_addr = 5'h00;
  logic rd_strobe;
  logic [4:0] rd_addr;
  logic xo_en = 1'h0;
  logic xo_force = 1'h0;
  logic qual = 1'h0;
  pss_pkg::pss_src_t src = '0;
  logic [15:0] word;
  logic take = 1'h0; // High for one cycle when a noted word is due.
  logic [15:0] exp_q[$];
  logic xo, pol, sdb, lkb, pg; // Expected field values.
  logic [2:0] lat; // Expected sticky flags: receive error, false carrier, remote fault.
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int ev;
  logic [31:0] seed = 32'h00000061;

  always #12.5 ref_clk = ~ref_clk;

  pss_mgmt_model pss_mgmt_model_inst (.ref_clk(ref_clk), .reset(reset), .go(go),
    .go_addr(go_addr), .rd_strobe(rd_strobe), .rd_addr(rd_addr));

  pss_summary pss_summary_inst (.ref_clk(ref_clk), .reset(reset), .rd_strobe(rd_strobe),
    .rd_addr(rd_addr), .auto_crossover_enable(xo_en), .crossover_force(xo_force),
    .lock_qualify_enable(qual), .src(src), .phy_summary_status(word));

  // Pseudo-random source for level inputs.
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Lets the word settle, then notes the expected value for the monitor.
  task automatic note();
    tick(4);
    exp_q.push_back({1'h0, xo, lat[2], pol, lat[1], sdb, lkb, pg, 1'h0, lat[0], 6'h00});
    take <= 1'h1;
    tick(1);
    take <= 1'h0;
  endtask

  // Asks the controller model for one register read.
  task automatic rd(input logic [4:0] a);
    go <= 1'h1;
    go_addr <= a;
    tick(1);
    go <= 1'h0;
  endtask

  // Monitor: compares the oldest note with the word when one is due.
  always @(negedge ref_clk) begin
    if (take) begin
      num_checks++;
      if (word !== exp_q[0]) begin
        failures++;
        $display("MISMATCH %0t word %h expected %h", $time, word, exp_q[0]);
      end
      void'(exp_q.pop_front());
    end
  end

  // Cuts a hang short well beyond the expected run length.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end

  initial begin
    {xo, pol, sdb, lkb, pg, lat} = '0;
    tick(6);
    reset <= 1'h0;
    note();
    // Every force, enable and pair combination.
    for (int i = 0; i < 8; i++) begin
      xo_force <= i[2];
      xo_en <= i[1];
      src.crossover_swapped <= i[0];
      xo = i[2] | (i[1] & i[0]);
      note();
    end
    // Each sticky flag: set, survives a summary read, cleared by its own register.
    for (int k = 0; k < 3; k++) begin
      ev = (k == 0) ? 6 : ((k == 1) ? 4 : 0);
      src[ev] <= 1'h1;
      tick(1);
      src[ev] <= 1'h0;
      lat[2-k] = 1'h1;
      note();
      rd(pss_pkg::PSS_ADDR_SUMMARY);
      note();
      rd((k == 0) ? pss_pkg::PSS_ADDR_RX_ERROR :
        ((k == 1) ? pss_pkg::PSS_ADDR_FALSE_CARRIER : pss_pkg::PSS_ADDR_BASIC_STATUS));
      lat[2-k] = 1'h0;
      note();
    end
    // An error landing on the clearing read edge must survive it.
    go <= 1'h1;
    go_addr <= pss_pkg::PSS_ADDR_RX_ERROR;
    tick(1);
    go <= 1'h0;
    src.rx_error_event <= 1'h1;
    tick(1);
    src.rx_error_event <= 1'h0;
    lat[2] = 1'h1;
    note();
    // Mirrored levels follow their sources and ignore summary reads.
    for (int j = 0; j < 6; j++) begin
      seed = xorshift(seed);
      src.polarity_inverted <= seed[0];
      src.page_received <= seed[1];
      pol = seed[0];
      pg = seed[1];
      rd(pss_pkg::PSS_ADDR_SUMMARY);
      note();
    end
    // Latch-low detect and lock with qualification on.
    src.raw_signal_detect <= 1'h1;
    src.descrambler_lock <= 1'h1;
    qual <= 1'h1;
    tick(2);
    rd(pss_pkg::PSS_ADDR_SUMMARY);
    {sdb, lkb} = 2'h3;
    note();
    src.descrambler_lock <= 1'h0;
    tick(2);
    src.descrambler_lock <= 1'h1;
    {sdb, lkb} = 2'h0;
    note();
    rd(pss_pkg::PSS_ADDR_SUMMARY);
    {sdb, lkb} = 2'h3;
    note();
    // Qualification off: detect ignores lock.
    qual <= 1'h0;
    src.descrambler_lock <= 1'h0;
    tick(2);
    rd(pss_pkg::PSS_ADDR_SUMMARY);
    {sdb, lkb} = 2'h2;
    note();
    src.raw_signal_detect <= 1'h0;
    tick(2);
    src.raw_signal_detect <= 1'h1;
    sdb = 1'h0;
    note();
    // A reset in mid-run clears every flag; mirrors come straight back.
    src.remote_fault_event <= 1'h1;
    tick(1);
    src.remote_fault_event <= 1'h0;
    reset <= 1'h1;
    tick(2);
    reset <= 1'h0;
    {sdb, lkb, lat} = '0;
    note();
    wrap_up();
  end
endmodule // test_pss_summary

// ---- core/pss_flag.sv ----
`timescale 1ns/1ps

// Sticky flag: set by an event, cleared by a read strobe, set wins the tie.
module pss_flag (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag
);

  logic flag_q; // Held flag value.
  logic flag_d; // Next flag value.

  // Next value: a set in the clear cycle is not lost.
  always_comb begin
    flag_d = flag_q;
    if (clear_in) begin
      flag_d = 1'b0;
    end
    if (set_in) begin
      flag_d = 1'b1;
    end
  end

  // Register the flag.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag = flag_q;

endmodule // pss_flag

// ---- core/pss_pkg.sv ----
package pss_pkg;

  // Register offsets on the management register map.
  localparam logic [4:0] PSS_ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PSS_ADDR_NEG_EXPANSION = 5'h06;
  localparam logic [4:0] PSS_ADDR_SUMMARY = 5'h10;
  localparam logic [4:0] PSS_ADDR_FALSE_CARRIER = 5'h14;
  localparam logic [4:0] PSS_ADDR_RX_ERROR = 5'h15;
  localparam logic [4:0] PSS_ADDR_TENBASE_STATUS = 5'h12;

  // Field positions inside the summary status word.
  localparam int PSS_BIT_RSVD_HI = 15;
  localparam int PSS_BIT_CROSSOVER = 14;
  localparam int PSS_BIT_RX_ERR = 13;
  localparam int PSS_BIT_POLARITY = 12;
  localparam int PSS_BIT_FALSE_CARRIER = 11;
  localparam int PSS_BIT_SIG_DET = 10;
  localparam int PSS_BIT_DESCR_LOCK = 9;
  localparam int PSS_BIT_PAGE_RX = 8;
  localparam int PSS_BIT_RSVD_LO = 7;
  localparam int PSS_BIT_REMOTE_FAULT = 6;

  // Reset value of the upper summary word.
  localparam logic [15:0] PSS_SUMMARY_RESET = 16'h0000;

  // Raw status sources arriving from the rest of the device.
  typedef struct packed {
    logic crossover_swapped;   // Pair assignment chosen by crossover logic.
    logic rx_error_event;      // One-cycle receive error event.
    logic polarity_inverted;   // Inverted polarity level from 10BASE-T status.
    logic false_carrier_event; // One-cycle false carrier event.
    logic raw_signal_detect;   // Raw signal detect from the medium.
    logic descrambler_lock;    // Descrambler lock from the medium sublayer.
    logic page_received;       // Page-received flag of negotiation expansion.
    logic remote_fault_event;  // One-cycle remote fault notification.
  } pss_src_t;

  // Register read strobes decoded from the management access.
  typedef struct packed {
    logic basic_status;
    logic neg_expansion;
    logic summary;
    logic false_carrier;
    logic rx_error;
  } pss_rd_t;

endpackage // pss_pkg

// ---- core/pss_summary.sv ----
`timescale 1ns/1ps

// How it works
// - Bits 15 and 7 read zero, ignore writes.
// - Bit 14 shows pair swap state.
// - Crossover bit follows enable and force live.
// - Bit 13 latches receive error, cleared by 15h.
// - Bit 12 mirrors polarity, cleared elsewhere.
// - Bit 11 latches false carrier, cleared by 14h.
// - Bit 10 is detect, optionally ANDed with lock.
// - Bit 9 is latch-low descrambler lock.
// - Bit 8 mirrors page received, cleared by 06h.
// - Bit 6 latches remote fault, cleared by 01h.
module pss_summary (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic rd_strobe,
  input wire logic [4:0] rd_addr,
  input wire logic auto_crossover_enable,
  input wire logic crossover_force,
  input wire logic lock_qualify_enable,
  input wire pss_pkg::pss_src_t src,
  output logic [15:0] phy_summary_status
);

  pss_pkg::pss_rd_t rd;     // Decoded read strobes.
  logic rx_err_flag;        // Receive error latch.
  logic false_carrier_flag; // False carrier latch.
  logic remote_fault_flag;  // Remote fault latch.
  logic qual_detect;        // Qualified signal detect level.
  logic crossover_q;        // Reported pair assignment.
  logic crossover_d;
  logic sig_det_q;          // Latch-low signal detect.
  logic sig_det_d;
  logic lock_q;             // Latch-low descrambler lock.
  logic lock_d;
  logic [15:0] word_q;      // Registered summary word.
  logic [15:0] word_d;

  // Decode which register the read strobe names.
  always_comb begin
    rd.basic_status = rd_strobe && (rd_addr == pss_pkg::PSS_ADDR_BASIC_STATUS);
    rd.neg_expansion = rd_strobe && (rd_addr == pss_pkg::PSS_ADDR_NEG_EXPANSION);
    rd.summary = rd_strobe && (rd_addr == pss_pkg::PSS_ADDR_SUMMARY);
    rd.false_carrier = rd_strobe && (rd_addr == pss_pkg::PSS_ADDR_FALSE_CARRIER);
    rd.rx_error = rd_strobe && (rd_addr == pss_pkg::PSS_ADDR_RX_ERROR);
  end

  // Receive error latch cleared by reading the error counter.
  pss_flag u_rx_err (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_in(src.rx_error_event),
    .clear_in(rd.rx_error),
    .flag(rx_err_flag)
  );

  // False carrier latch cleared by reading the false carrier counter.
  pss_flag u_false_carrier (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_in(src.false_carrier_event),
    .clear_in(rd.false_carrier),
    .flag(false_carrier_flag)
  );

  // Remote fault latch cleared by reading the basic status register.
  pss_flag u_remote_fault (
    .ref_clk(ref_clk),
    .reset(reset),
    .set_in(src.remote_fault_event),
    .clear_in(rd.basic_status),
    .flag(remote_fault_flag)
  );

  // Qualified detect: AND with lock only when qualification is enabled.
  assign qual_detect = lock_qualify_enable ? (src.raw_signal_detect && src.descrambler_lock)
                                           : src.raw_signal_detect;

  // Next values for crossover and the latch-low bits.
  always_comb begin
    // Forced swap wins; enabled tracks live; disabled stays normal.
    if (crossover_force) begin
      crossover_d = 1'b1;
    end else if (auto_crossover_enable) begin
      crossover_d = src.crossover_swapped;
    end else begin
      crossover_d = 1'b0;
    end
    // A summary read reloads the live level; otherwise a drop holds.
    if (rd.summary) begin
      sig_det_d = qual_detect;
      lock_d = src.descrambler_lock;
    end else begin
      sig_det_d = sig_det_q && qual_detect;
      lock_d = lock_q && src.descrambler_lock;
    end
  end

  // Assemble the word; reserved bits and lower bits stay zero.
  always_comb begin
    word_d = pss_pkg::PSS_SUMMARY_RESET;
    word_d[pss_pkg::PSS_BIT_RSVD_HI] = 1'b0;
    word_d[pss_pkg::PSS_BIT_CROSSOVER] = crossover_q;
    word_d[pss_pkg::PSS_BIT_RX_ERR] = rx_err_flag;
    word_d[pss_pkg::PSS_BIT_POLARITY] = src.polarity_inverted;
    word_d[pss_pkg::PSS_BIT_FALSE_CARRIER] = false_carrier_flag;
    word_d[pss_pkg::PSS_BIT_SIG_DET] = sig_det_q;
    word_d[pss_pkg::PSS_BIT_DESCR_LOCK] = lock_q;
    word_d[pss_pkg::PSS_BIT_PAGE_RX] = src.page_received;
    word_d[pss_pkg::PSS_BIT_RSVD_LO] = 1'b0;
    word_d[pss_pkg::PSS_BIT_REMOTE_FAULT] = remote_fault_flag;
  end

  // Register state; latch-low bits start low after reset.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crossover_q <= 1'b0;
      sig_det_q <= 1'b0;
      lock_q <= 1'b0;
      word_q <= pss_pkg::PSS_SUMMARY_RESET;
    end else begin
      crossover_q <= crossover_d;
      sig_det_q <= sig_det_d;
      lock_q <= lock_d;
      word_q <= word_d;
    end
  end

  assign phy_summary_status = word_q;

  // Reserved bits never read one.
  property p_rsvd_zero;
    @(posedge ref_clk) disable iff (reset)
      !phy_summary_status[15] && !phy_summary_status[7];
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  // Live crossover tracking shows two cycles later.
  property p_cross_live;
    @(posedge ref_clk) disable iff (reset)
      (auto_crossover_enable && !crossover_force) ##1 (auto_crossover_enable && !crossover_force)
      |=> phy_summary_status[14] == $past(src.crossover_swapped, 2);
  endproperty
  a_cross_live: assert property (p_cross_live) else $error("crossover not live");

  // Force gives swapped pairs.
  property p_cross_force;
    @(posedge ref_clk) disable iff (reset)
      crossover_force ##1 1'b1 |=> phy_summary_status[14];
  endproperty
  a_cross_force: assert property (p_cross_force) else $error("force ignored");

  // A receive error shows within two cycles.
  property p_rx_err_set;
    @(posedge ref_clk) disable iff (reset)
      src.rx_error_event |-> ##2 phy_summary_status[13];
  endproperty
  a_rx_err_set: assert property (p_rx_err_set) else $error("rx error lost");

  // Reading the summary word does not clear the receive error latch.
  property p_rx_err_hold;
    @(posedge ref_clk) disable iff (reset)
      rx_err_flag && !rd.rx_error |=> rx_err_flag;
  endproperty
  a_rx_err_hold: assert property (p_rx_err_hold) else $error("rx latch dropped");

  // Polarity mirrors its source one cycle late.
  property p_polarity;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> phy_summary_status[12] == $past(src.polarity_inverted);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity mismatch");

  // False carrier read without event clears the latch.
  property p_fc_clear;
    @(posedge ref_clk) disable iff (reset)
      rd.false_carrier && !src.false_carrier_event |=> !false_carrier_flag;
  endproperty
  a_fc_clear: assert property (p_fc_clear) else $error("false carrier not cleared");

  // A detect drop, or a low already held, stays low until a summary read.
  property p_sd_low;
    @(posedge ref_clk) disable iff (reset)
      (!qual_detect || !sig_det_q) && !rd.summary |=> !sig_det_q;
  endproperty
  a_sd_low: assert property (p_sd_low) else $error("detect not latched low");

  // Lock bit never high in the cycle after lock is low.
  property p_lock_low;
    @(posedge ref_clk) disable iff (reset)
      !src.descrambler_lock |=> !lock_q;
  endproperty
  a_lock_low: assert property (p_lock_low) else $error("lock high without lock");

  // Page received mirrors its source.
  property p_page;
    @(posedge ref_clk) disable iff (reset)
      1'b1 |=> phy_summary_status[8] == $past(src.page_received);
  endproperty
  a_page: assert property (p_page) else $error("page mismatch");

  // Remote fault event shows within two cycles.
  property p_rf;
    @(posedge ref_clk) disable iff (reset)
      src.remote_fault_event |-> ##2 phy_summary_status[6];
  endproperty
  a_rf: assert property (p_rf) else $error("remote fault lost");

  // A summary read with lock high reloads a one.
  property p_reload;
    @(posedge ref_clk) disable iff (reset)
      rd.summary && src.descrambler_lock |=> lock_q;
  endproperty
  a_reload: assert property (p_reload) else $error("lock not reloaded");

endmodule // pss_summary
